// ===== hdl/status_pkg.sv
// Shared constants and types for the status summary and reply formatter.
// Assumes a single 10 MHz clock domain and byte-wide reply characters.
package status_pkg;
	localparam int BYTE_W = 8;
	localparam int COND_W = 3;
	localparam int REPLY_MAX = 8;
	// Status summary byte bit positions
	localparam int BIT_OVERLOAD = 0;
	localparam int BIT_UPPER = 1;
	localparam int BIT_LOWER = 2;
	localparam int BIT_UNDEF = 3;
	localparam int BIT_IDLE = 4;
	localparam int BIT_STD = 5;
	localparam int BIT_MASTER = 6;
	localparam int BIT_COMM = 7;
	// Reset values and implemented mask bits
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] SRQ_MASK_IMPL = 8'hbf;
	localparam logic TOKEN_RESET = 1'b0;
	// Reply characters
	localparam logic [7:0] CHAR_CR = 8'h0d;
	localparam logic [7:0] CHAR_LF = 8'h0a;
	localparam logic [7:0] CHAR_ZERO = 8'h30;
	localparam logic [7:0] CHAR_C = 8'h43;
	localparam logic [7:0] CHAR_E = 8'h45;
	localparam logic [7:0] CHAR_F = 8'h46;
	localparam logic [7:0] CHAR_L = 8'h4c;
	localparam logic [7:0] CHAR_N = 8'h4e;
	localparam logic [7:0] CHAR_O = 8'h4f;
	localparam logic [7:0] CHAR_R = 8'h52;
	localparam logic [7:0] DEC_HUNDRED = 8'h64;
	localparam logic [7:0] DEC_TEN = 8'h0a;
	typedef enum logic [2:0] {
		TERM_NONE = 3'h0,
		TERM_CR = 3'h1,
		TERM_LF = 3'h2,
		TERM_CRLF = 3'h3,
		TERM_LFCR = 3'h4
	} term_type;
	localparam term_type TERM_RESET = TERM_CRLF;
	typedef enum logic [1:0] {
		REPLY_DECIMAL = 2'h0,
		REPLY_ON = 2'h1,
		REPLY_TERM_WORD = 2'h2
	} reply_kind_type;
	typedef enum logic [3:0] {
		CMD_STB_QUERY = 4'h0,
		CMD_SRQ_SET = 4'h1,
		CMD_SRQ_QUERY = 4'h2,
		CMD_TOKEN_SET = 4'h3,
		CMD_TOKEN_QUERY = 4'h4,
		CMD_TERM_SET = 4'h5,
		CMD_TERM_QUERY = 4'h6,
		CMD_STD_SET = 4'h7,
		CMD_STD_QUERY = 4'h8,
		CMD_COMM_SET = 4'h9,
		CMD_COMM_QUERY = 4'ha,
		CMD_COND_QUERY = 4'hb
	} cmd_type;
endpackage : status_pkg

// ===== hdl/reply_if.sv
// Reply request carrier between the status core and the reply former.
// Assumes both ends share sys_clk_i; a request moves when valid and ready.
`timescale 1ns/1ps
interface reply_if;
	logic valid;
	logic ready;
	status_pkg::reply_kind_type kind;
	logic [7:0] value;
	status_pkg::term_type term;
	modport source (output valid, output kind, output value, output term,
		input ready);
	modport sink (input valid, input kind, input value, input term,
		output ready);
endinterface : reply_if

// ===== hdl/event_latch.sv
// Sticky event bits set by rising edges of live condition inputs.
// Assumes conditions are synchronous; a clear pulse empties every bit without a new rising edge that cycle.
`timescale 1ns/1ps
module event_latch #(
	parameter int WIDTH = 3
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] cond_i,
	input wire logic clear_i,
	output logic [WIDTH-1:0] sticky_o
);
	typedef struct packed {
		logic [WIDTH-1:0] prev;
		logic [WIDTH-1:0] sticky;
	} latch_state_type;

	latch_state_type st;
	latch_state_type next_st;
	logic [WIDTH-1:0] rise;

	if (WIDTH < 1) begin : g_check
		$error("event_latch needs at least one bit");
	end

	// Edge detect per bit
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		assign rise[i] = cond_i[i] & ~st.prev[i];
	end

	// A new edge beats a clear in the same cycle
	always_comb begin
		next_st = st;
		next_st.prev = cond_i;
		next_st.sticky = (clear_i ? '0 : st.sticky) | rise;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign sticky_o = st.sticky;
endmodule : event_latch

// ===== hdl/reply_former.sv
// Turns a reply request into ASCII characters plus the terminator.
// Assumes the sink may stall; one character leaves per accepted cycle.
`timescale 1ns/1ps
module reply_former #(
	parameter int DEPTH = status_pkg::REPLY_MAX
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	reply_if.sink rq,
	output logic out_valid_o,
	output logic [7:0] out_byte_o,
	input wire logic out_ready_i
);
	typedef struct packed {
		logic busy;
		logic [DEPTH-1:0][7:0] chars;
		logic [3:0] len;
		logic [3:0] idx;
		logic out_valid;
		logic [7:0] out_byte;
	} former_state_type;

	former_state_type st;
	former_state_type next_st;

	if (DEPTH < 6 || DEPTH > 15) begin : g_check
		$error("reply_former DEPTH must be 6 to 15");
	end

	// Build text then terminator; leading zeros suppressed
	always_comb begin
		logic [DEPTH-1:0][7:0] c;
		logic [3:0] n;
		logic [7:0] h;
		logic [7:0] t;
		logic [7:0] o;
		next_st = st;
		c = '0;
		n = '0;
		h = rq.value / status_pkg::DEC_HUNDRED;
		t = (rq.value / status_pkg::DEC_TEN) % status_pkg::DEC_TEN;
		o = rq.value % status_pkg::DEC_TEN;
		if (st.out_valid && out_ready_i) begin
			next_st.out_valid = 1'b0;
		end
		if (st.busy && (!st.out_valid || out_ready_i)) begin
			next_st.out_byte = st.chars[st.idx];
			next_st.out_valid = 1'b1;
			next_st.idx = st.idx + 4'h1;
			next_st.busy = (st.idx + 4'h1) != st.len;
		end else if (!st.busy && rq.valid) begin
			unique case (rq.kind)
				status_pkg::REPLY_ON: begin
					c[0] = status_pkg::CHAR_O;
					c[1] = status_pkg::CHAR_N;
					n = 4'h2;
				end
				status_pkg::REPLY_TERM_WORD: begin
					unique case (rq.value[2:0])
						status_pkg::TERM_NONE: begin
							c[0] = status_pkg::CHAR_N;
							c[1] = status_pkg::CHAR_O;
							c[2] = status_pkg::CHAR_N;
							c[3] = status_pkg::CHAR_E;
							n = 4'h4;
						end
						status_pkg::TERM_CR: begin
							c[0] = status_pkg::CHAR_C;
							c[1] = status_pkg::CHAR_R;
							n = 4'h2;
						end
						status_pkg::TERM_LF: begin
							c[0] = status_pkg::CHAR_L;
							c[1] = status_pkg::CHAR_F;
							n = 4'h2;
						end
						status_pkg::TERM_CRLF: begin
							c[0] = status_pkg::CHAR_C;
							c[1] = status_pkg::CHAR_R;
							c[2] = status_pkg::CHAR_L;
							c[3] = status_pkg::CHAR_F;
							n = 4'h4;
						end
						default: begin
							c[0] = status_pkg::CHAR_L;
							c[1] = status_pkg::CHAR_F;
							c[2] = status_pkg::CHAR_C;
							c[3] = status_pkg::CHAR_R;
							n = 4'h4;
						end
					endcase
				end
				default: begin
					if (h != 8'h00) begin
						c[n] = status_pkg::CHAR_ZERO + h;
						n = n + 4'h1;
					end
					if (h != 8'h00 || t != 8'h00) begin
						c[n] = status_pkg::CHAR_ZERO + t;
						n = n + 4'h1;
					end
					c[n] = status_pkg::CHAR_ZERO + o;
					n = n + 4'h1;
				end
			endcase
			// Terminator taken as selected when the query was taken
			if (rq.term == status_pkg::TERM_CR ||
				rq.term == status_pkg::TERM_CRLF) begin
				c[n] = status_pkg::CHAR_CR;
				n = n + 4'h1;
			end
			if (rq.term == status_pkg::TERM_LF ||
				rq.term == status_pkg::TERM_CRLF ||
				rq.term == status_pkg::TERM_LFCR) begin
				c[n] = status_pkg::CHAR_LF;
				n = n + 4'h1;
			end
			if (rq.term == status_pkg::TERM_LFCR) begin
				c[n] = status_pkg::CHAR_CR;
				n = n + 4'h1;
			end
			next_st.chars = c;
			next_st.len = n;
			next_st.idx = 4'h0;
			next_st.busy = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rq.ready = !st.busy;
	assign out_valid_o = st.out_valid;
	assign out_byte_o = st.out_byte;
endmodule : reply_former

// ===== hdl/status_summary_core.sv
// Status summary byte, service request mask, attention line and replies.
// Assumes commands and condition inputs are synchronous to sys_clk_i.
// Notes on behaviour
// [R1] Token keyword mode on: token queries answer keyword, else decimal
// [R2] Token mode off at reset; its query answers ON or 0 only
// [R3] Terminator codes: none 0, CR 1, LF 2, CRLF 3, LFCR 4
// [R4] Selected terminator follows every query reply
// [R5] Terminator setting powers up as CRLF, code 3
// [R6] Condition query shows live conditions with no side effect
// [R7] Event bits set on event, stay set, cleared by their read
// [R8] Enable mask ANDs its event bits into one summary bit
// [R9] Attention line goes low when a masked summary bit is set
// [R10] Status byte query raises attention; only newly set masked summary bits lower it
// [R11] Bit 0 set by rising overload condition
// [R12] Bit 1 set by rising upper clamp condition
// [R13] Bit 2 set by rising lower clamp condition
// [R14] Bit 4 is input buffer empty and parser idle
// [R15] Bit 5 is OR of enabled standard event flags
// [R16] Bit 6 is OR of masked summary bits, not cleared by query
// [R17] Bit 7 is OR of enabled communication error flags
// [R18] Bits 0 to 2 hold until status byte query clears them
// [R19] Other summary bits follow their sources, not the status query
// [R20] Service request mask bit 6 unimplemented, reads 0
// [R21] Service request mask settable, queryable, zero at power-on
// [R22] Standard event mask forms bit 5, zero at power-on
// [R23] Bit 3 always reads 0
// [R24] Host queries status byte after attention goes low
`timescale 1ns/1ps
module status_summary_core (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic overload_condition_i,
	input wire logic upper_clamp_condition_i,
	input wire logic lower_clamp_condition_i,
	input wire logic input_buffer_empty_i,
	input wire logic parser_idle_i,
	input wire logic [7:0] standard_event_flags_i,
	input wire logic [7:0] comm_error_flags_i,
	input wire logic cmd_valid_i,
	input wire logic [3:0] cmd_op_i,
	input wire logic [7:0] cmd_arg_i,
	output logic cmd_ready_o,
	output logic reply_valid_o,
	output logic [7:0] reply_byte_o,
	input wire logic reply_ready_i,
	output logic attention_n_o
);
	typedef struct packed {
		logic [7:0] service_request_mask;
		logic [7:0] standard_event_mask;
		logic [7:0] comm_error_mask;
		logic token_keyword_mode;
		status_pkg::term_type term;
		logic rq_valid;
		status_pkg::reply_kind_type rq_kind;
		logic [7:0] rq_value;
		status_pkg::term_type rq_term;
		logic [7:0] prev_masked;
		logic attention_n;
		logic cmd_ready;
	} core_state_type;

	localparam core_state_type RESET_STATE = '{
		service_request_mask: status_pkg::MASK_RESET,
		standard_event_mask: status_pkg::MASK_RESET,
		comm_error_mask: status_pkg::MASK_RESET,
		token_keyword_mode: status_pkg::TOKEN_RESET,
		term: status_pkg::TERM_RESET,
		rq_valid: 1'b0,
		rq_kind: status_pkg::REPLY_DECIMAL,
		rq_value: 8'h00,
		rq_term: status_pkg::TERM_RESET,
		prev_masked: 8'h00,
		attention_n: 1'b1,
		cmd_ready: 1'b1
	};

	core_state_type st;
	core_state_type next_st;
	reply_if rq_link ();

	logic [2:0] conditions;
	logic [2:0] event_bits;
	logic [7:0] sb_low;
	logic [7:0] status_summary_byte;
	logic [7:0] masked;
	logic master_summary_bit;
	logic standard_event_summary;
	logic comm_error_summary;
	logic accept;
	logic stb_query;
	logic new_request;
	status_pkg::cmd_type op;

	assign conditions = {lower_clamp_condition_i, upper_clamp_condition_i,
		overload_condition_i};
	assign op = status_pkg::cmd_type'(cmd_op_i);
	assign accept = cmd_valid_i && st.cmd_ready;
	assign stb_query = accept && op == status_pkg::CMD_STB_QUERY;

	// Sticky overload and clamp bits, emptied by the status byte query
	event_latch #(
		.WIDTH(status_pkg::COND_W)
	) u_events (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.cond_i(conditions), // R11 R12 R13
		.clear_i(stb_query), // R18
		.sticky_o(event_bits) // R7
	);

	// Summary inputs; flag registers live outside and clear on their read
	assign standard_event_summary =
		|(standard_event_flags_i & st.standard_event_mask); // R8 R15 R22
	assign comm_error_summary =
		|(comm_error_flags_i & st.comm_error_mask); // R17 R19

	// Byte without the master bit, so the master bit cannot feed itself
	always_comb begin
		sb_low = 8'h00;
		sb_low[status_pkg::BIT_OVERLOAD] = event_bits[0];
		sb_low[status_pkg::BIT_UPPER] = event_bits[1];
		sb_low[status_pkg::BIT_LOWER] = event_bits[2];
		sb_low[status_pkg::BIT_UNDEF] = 1'b0; // R23
		sb_low[status_pkg::BIT_IDLE] =
			input_buffer_empty_i && parser_idle_i; // R14
		sb_low[status_pkg::BIT_STD] = standard_event_summary;
		sb_low[status_pkg::BIT_COMM] = comm_error_summary;
	end

	// Mask bit 6 is held at zero, so masking sb_low is exact
	assign masked = sb_low & st.service_request_mask;
	assign master_summary_bit = |masked; // R16
	always_comb begin
		status_summary_byte = sb_low;
		status_summary_byte[status_pkg::BIT_MASTER] = master_summary_bit;
	end

	// A masked bit turning on is a new service request
	assign new_request = |(masked & ~st.prev_masked);

	// Command decode, reply request and attention line
	always_comb begin
		next_st = st;
		next_st.prev_masked = masked;
		if (st.rq_valid && rq_link.ready) begin
			next_st.rq_valid = 1'b0;
		end
		if (accept) begin
			next_st.rq_kind = status_pkg::REPLY_DECIMAL;
			next_st.rq_term = st.term; // R4
			unique case (op)
				status_pkg::CMD_STB_QUERY: begin
					next_st.rq_value = status_summary_byte;
					next_st.rq_valid = 1'b1;
				end
				status_pkg::CMD_SRQ_SET: begin
					next_st.service_request_mask =
						cmd_arg_i & status_pkg::SRQ_MASK_IMPL; // R20 R21
				end
				status_pkg::CMD_SRQ_QUERY: begin
					next_st.rq_value = st.service_request_mask; // R21
					next_st.rq_valid = 1'b1;
				end
				status_pkg::CMD_TOKEN_SET: begin
					next_st.token_keyword_mode = cmd_arg_i[0];
				end
				status_pkg::CMD_TOKEN_QUERY: begin
					// Only ON or 0 can come back
					next_st.rq_kind = st.token_keyword_mode ?
						status_pkg::REPLY_ON : status_pkg::REPLY_DECIMAL; // R2
					next_st.rq_value = 8'h00;
					next_st.rq_valid = 1'b1;
				end
				status_pkg::CMD_TERM_SET: begin
					// Out-of-range codes are ignored, setting kept
					if (cmd_arg_i <= 8'(status_pkg::TERM_LFCR)) begin
						next_st.term =
							status_pkg::term_type'(cmd_arg_i[2:0]); // R3
					end
				end
				status_pkg::CMD_TERM_QUERY: begin
					next_st.rq_kind = st.token_keyword_mode ?
						status_pkg::REPLY_TERM_WORD :
						status_pkg::REPLY_DECIMAL; // R1
					next_st.rq_value = {5'h00, st.term};
					next_st.rq_valid = 1'b1;
				end
				status_pkg::CMD_STD_SET: begin
					next_st.standard_event_mask = cmd_arg_i; // R22
				end
				status_pkg::CMD_STD_QUERY: begin
					next_st.rq_value = st.standard_event_mask;
					next_st.rq_valid = 1'b1;
				end
				status_pkg::CMD_COMM_SET: begin
					next_st.comm_error_mask = cmd_arg_i;
				end
				status_pkg::CMD_COMM_QUERY: begin
					next_st.rq_value = st.comm_error_mask;
					next_st.rq_valid = 1'b1;
				end
				status_pkg::CMD_COND_QUERY: begin
					next_st.rq_value = {5'h00, conditions}; // R6
					next_st.rq_valid = 1'b1;
				end
				default: begin
					// Unknown opcodes are consumed and ignored
					next_st.rq_valid = st.rq_valid && !rq_link.ready;
				end
			endcase
		end
		// New request wins over the query that releases the line
		if (new_request) begin
			next_st.attention_n = 1'b0; // R9
		end else if (stb_query) begin
			next_st.attention_n = 1'b1; // R10
		end
		// One command in flight; sets wait too, keeping order simple
		next_st.cmd_ready = !next_st.rq_valid;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= RESET_STATE; // R5 R2 R21
		end else begin
			st <= next_st;
		end
	end

	assign rq_link.valid = st.rq_valid;
	assign rq_link.kind = st.rq_kind;
	assign rq_link.value = st.rq_value;
	assign rq_link.term = st.rq_term;

	// Characters leave through the former's own output flops
	reply_former #(
		.DEPTH(status_pkg::REPLY_MAX)
	) u_former (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.rq(rq_link),
		.out_valid_o(reply_valid_o),
		.out_byte_o(reply_byte_o),
		.out_ready_i(reply_ready_i)
	);

	assign cmd_ready_o = st.cmd_ready;
	assign attention_n_o = st.attention_n;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_stb_alone;
		stb_query && !new_request;
	endsequence
	sequence s_released;
		##1 attention_n_o;
	endsequence

	a_mask_bit_six: assert property (
		!st.service_request_mask[status_pkg::BIT_MASTER]) // R20
		else $error("service request mask bit 6 set");
	a_undef_bit_zero: assert property (
		!status_summary_byte[status_pkg::BIT_UNDEF]) // R23
		else $error("summary bit 3 not zero");
	a_overload_sets: assert property (
		$rose(overload_condition_i) |=> event_bits[0]) // R11
		else $error("overload edge did not set bit 0");
	a_upper_sets: assert property (
		$rose(upper_clamp_condition_i) |=> event_bits[1]) // R12
		else $error("upper clamp edge did not set bit 1");
	a_lower_sets: assert property (
		$rose(lower_clamp_condition_i) |=> event_bits[2]) // R13
		else $error("lower clamp edge did not set bit 2");
	a_stb_clears_events: assert property (
		stb_query && ($past(conditions) | ~conditions) == 3'h7
		|=> event_bits == 3'h0) // R18
		else $error("status query left event bits set");
	a_events_hold: assert property (
		event_bits[0] && !stb_query |=> event_bits[0]) // R18
		else $error("overload bit dropped without query");
	a_idle_bit: assert property (
		status_summary_byte[status_pkg::BIT_IDLE] ==
		(input_buffer_empty_i && parser_idle_i)) // R14
		else $error("idle bit wrong");
	a_master_sum: assert property (
		status_summary_byte[status_pkg::BIT_MASTER] ==
		|(status_summary_byte & st.service_request_mask)) // R16
		else $error("master summary bit wrong");
	a_attn_assert: assert property (
		new_request |=> !attention_n_o) // R9
		else $error("attention not asserted on request");
	a_attn_release: assert property (s_stb_alone |-> s_released) // R10
		else $error("attention not released by status query");
	a_attn_stays: assert property (
		!new_request && !stb_query |=> $stable(attention_n_o)) // R10
		else $error("attention changed without cause");
	a_term_reject: assert property (
		accept && op == status_pkg::CMD_TERM_SET && cmd_arg_i > 8'h04
		|=> $stable(st.term)) // R3
		else $error("illegal terminator code stored");
	a_token_reply: assert property (
		accept && op == status_pkg::CMD_TOKEN_QUERY |=> st.rq_valid &&
		(st.rq_kind == status_pkg::REPLY_ON) == st.token_keyword_mode) // R2
		else $error("token mode reply malformed");
endmodule : status_summary_core

// ===== verif/host_reply_sink.sv
// Host side model that consumes reply characters from the status core.
// Assumes one clock; a byte counts as taken at an edge with valid and ready.
`timescale 1ns/1ps
module host_reply_sink (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic slow_i,
	input wire logic reply_valid_i,
	input wire logic [7:0] reply_byte_i,
	output logic reply_ready_o,
	output logic got_o,
	output logic [7:0] got_byte_o
);
	// Ready toggles when slow, so ready is low on every other cycle and each character after an accepted one waits a cycle
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reply_ready_o <= 1'b0;
			got_o <= 1'b0;
			got_byte_o <= 8'h00;
		end else begin
			got_o <= reply_valid_i && reply_ready_o;
			got_byte_o <= reply_byte_i;
			reply_ready_o <= slow_i ? !reply_ready_o : 1'b1;
		end
	end
endmodule : host_reply_sink

// ===== verif/tb_top.sv
// Self-checking bench: commands in, reply characters and attention out.
// Assumes the host sink model; all inputs change by NBA on rising edges.
`timescale 1ns/1ps
module tb_top;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic ovl = 1'b0;
	logic upc = 1'b0;
	logic loc = 1'b0;
	logic buf_empty = 1'b1;
	logic p_idle = 1'b1;
	logic slow = 1'b0;
	logic [7:0] std_flags = 8'h00;
	logic [7:0] comm_flags = 8'h00;
	logic cmd_valid = 1'b0;
	logic [3:0] cmd_op = 4'h0;
	logic [7:0] cmd_arg = 8'h00;
	logic cmd_ready;
	logic reply_valid;
	logic reply_ready;
	logic attention_n;
	logic got;
	logic [7:0] reply_byte;
	logic [7:0] got_byte;
	logic [7:0] rx_q[$];
	int error_cnt = 0;
	int checked = 0;
	int cur_term = 3;

	status_summary_core dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.overload_condition_i(ovl), .upper_clamp_condition_i(upc),
		.lower_clamp_condition_i(loc), .input_buffer_empty_i(buf_empty),
		.parser_idle_i(p_idle), .standard_event_flags_i(std_flags),
		.comm_error_flags_i(comm_flags), .cmd_valid_i(cmd_valid),
		.cmd_op_i(cmd_op), .cmd_arg_i(cmd_arg), .cmd_ready_o(cmd_ready),
		.reply_valid_o(reply_valid), .reply_byte_o(reply_byte),
		.reply_ready_i(reply_ready), .attention_n_o(attention_n));

	host_reply_sink host_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.slow_i(slow), .reply_valid_i(reply_valid),
		.reply_byte_i(reply_byte), .reply_ready_o(reply_ready),
		.got_o(got), .got_byte_o(got_byte));

	// 10 MHz clock
	always #50 sys_clk_i = ~sys_clk_i;

	// Collect every character the host took; sampled mid-cycle to stay clear
	// of the sink's own update edge
	always @(negedge sys_clk_i) begin
		if (got === 1'b1)
			rx_q.push_back(got_byte);
	end

	task give_verdict;
		$display("Checks %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk

	// Hold the command until ready is seen before the taking edge
	task automatic send(input logic [3:0] op, input logic [7:0] arg);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_arg <= arg;
		@(negedge sys_clk_i);
		while (cmd_ready !== 1'b1 && n < 40) begin
			@(negedge sys_clk_i);
			n++;
		end
		if (cmd_ready !== 1'b1) begin
			error_cnt++;
			$display("ERROR at %0t: command not taken", $time);
			give_verdict();
		end
		@(posedge sys_clk_i);
		cmd_valid <= 1'b0;
	endtask : send

	// Expected reply is the text followed by the current terminator
	task automatic query(input logic [3:0] op, input string txt);
		logic [7:0] exp_q[$];
		int n;
		rx_q = {};
		for (int i = 0; i < txt.len(); i++)
			exp_q.push_back(txt[i]);
		if (cur_term == 1 || cur_term == 3)
			exp_q.push_back(status_pkg::CHAR_CR);
		if (cur_term >= 2)
			exp_q.push_back(status_pkg::CHAR_LF);
		if (cur_term == 4)
			exp_q.push_back(status_pkg::CHAR_CR);
		send(op, 8'h00);
		n = 0;
		while (rx_q.size() < exp_q.size() && n < 80) begin
			@(posedge sys_clk_i);
			n++;
		end
		if (rx_q.size() < exp_q.size()) begin
			error_cnt++;
			$display("ERROR at %0t: reply timed out", $time);
			give_verdict();
		end
		repeat (4) @(posedge sys_clk_i);
		// Look between edges so registered outputs have settled
		@(negedge sys_clk_i);
		chk(8'(rx_q.size()), 8'(exp_q.size()));
		foreach (exp_q[i])
			if (i < rx_q.size())
				chk(rx_q[i], exp_q[i]);
	endtask : query

	// Attention may take a couple of edges to follow its cause
	task automatic wait_att(input logic lvl);
		int n;
		n = 0;
		while (attention_n !== lvl && n < 6) begin
			@(negedge sys_clk_i);
			n++;
		end
		chk({7'h00, attention_n}, {7'h00, lvl});
	endtask : wait_att

	task automatic test_done(input string name);
		$display("Test %s done, mismatches so far %0d", name, error_cnt);
	endtask : test_done

	// Main sequence
	initial begin
		repeat (12) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		@(negedge sys_clk_i);
		chk({7'h00, attention_n}, 8'h01);
		query(status_pkg::CMD_SRQ_QUERY, "0");
		query(status_pkg::CMD_TOKEN_QUERY, "0");
		query(status_pkg::CMD_TERM_QUERY, "3");
		test_done("reset");
		for (int c = 0; c < 5; c++) begin
			send(status_pkg::CMD_TERM_SET, 8'(c));
			cur_term = c;
			query(status_pkg::CMD_SRQ_QUERY, "0");
		end
		send(status_pkg::CMD_TERM_SET, 8'h05);
		query(status_pkg::CMD_TERM_QUERY, "4");
		send(status_pkg::CMD_TERM_SET, 8'h03);
		cur_term = 3;
		test_done("terminator");
		send(status_pkg::CMD_TOKEN_SET, 8'h01);
		query(status_pkg::CMD_TOKEN_QUERY, "ON");
		query(status_pkg::CMD_TERM_QUERY, "CRLF");
		send(status_pkg::CMD_TOKEN_SET, 8'h00);
		query(status_pkg::CMD_TERM_QUERY, "3");
		@(posedge sys_clk_i);
		slow <= 1'b1;
		send(status_pkg::CMD_SRQ_SET, 8'hff);
		query(status_pkg::CMD_SRQ_QUERY, "191");
		@(posedge sys_clk_i);
		slow <= 1'b0;
		test_done("format");
		send(status_pkg::CMD_SRQ_SET, 8'h01);
		query(status_pkg::CMD_STB_QUERY, "16");
		@(posedge sys_clk_i);
		ovl <= 1'b1;
		wait_att(1'b0);
		query(status_pkg::CMD_STB_QUERY, "81");
		chk({7'h00, attention_n}, 8'h01);
		query(status_pkg::CMD_STB_QUERY, "16");
		chk({7'h00, attention_n}, 8'h01);
		query(status_pkg::CMD_COND_QUERY, "1");
		query(status_pkg::CMD_COND_QUERY, "1");
		@(posedge sys_clk_i);
		upc <= 1'b1;
		loc <= 1'b1;
		buf_empty <= 1'b0;
		query(status_pkg::CMD_COND_QUERY, "7");
		query(status_pkg::CMD_STB_QUERY, "6");
		chk({7'h00, attention_n}, 8'h01);
		@(posedge sys_clk_i);
		ovl <= 1'b0;
		upc <= 1'b0;
		loc <= 1'b0;
		buf_empty <= 1'b1;
		test_done("events");
		send(status_pkg::CMD_STD_SET, 8'h04);
		send(status_pkg::CMD_SRQ_SET, 8'h20);
		@(posedge sys_clk_i);
		std_flags <= 8'h04;
		wait_att(1'b0);
		query(status_pkg::CMD_STB_QUERY, "112");
		chk({7'h00, attention_n}, 8'h01);
		query(status_pkg::CMD_STB_QUERY, "112");
		query(status_pkg::CMD_STD_QUERY, "4");
		send(status_pkg::CMD_STD_SET, 8'h00);
		query(status_pkg::CMD_STB_QUERY, "16");
		send(status_pkg::CMD_COMM_SET, 8'h80);
		@(posedge sys_clk_i);
		comm_flags <= 8'h81;
		query(status_pkg::CMD_STB_QUERY, "144");
		@(posedge sys_clk_i);
		comm_flags <= 8'h00;
		query(status_pkg::CMD_STB_QUERY, "16");
		test_done("summary");
		// Mid-run reset must drop token mode and restore the terminator
		send(status_pkg::CMD_TOKEN_SET, 8'h01);
		send(status_pkg::CMD_TERM_SET, 8'h01);
		@(posedge sys_clk_i);
		rst_n_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		@(negedge sys_clk_i);
		chk({7'h00, attention_n}, 8'h01);
		query(status_pkg::CMD_TOKEN_QUERY, "0");
		query(status_pkg::CMD_TERM_QUERY, "3");
		query(status_pkg::CMD_SRQ_QUERY, "0");
		test_done("reset again");
		give_verdict();
	end
endmodule : tb_top
